// File: ddp_pkg.sv
// Constants, types and register map of the dual-channel phase control block.
package ddp_pkg;
    localparam int TUNE_W       = 52;
    localparam int TUNE_LO_W    = 32;
    localparam int TUNE_HI_W    = TUNE_W - TUNE_LO_W;
    localparam int PAR_W        = 16;
    localparam int SMP_W        = 16;
    localparam int ADDR_W       = 8;
    localparam int MULT_W       = 8;
    // Synthesis clock in MHz; output frequency = tuning word * clock / 2^52.
    localparam int DDS_CLK_MHZ  = 2500;

    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CH_ONE   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CH_TWO   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CPL_FREQ = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_CPL_AMP  = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_CPL_PH   = 8'h38;

    localparam int CTRL_LOCK     = 0;
    localparam int CTRL_TRACK    = 1;
    localparam int CTRL_COUPLE   = 2;
    localparam int CTRL_SUM_ONE  = 3;
    localparam int CTRL_SUM_TWO  = 4;
    localparam int CTRL_MULT_LSB = 8;
    localparam int CTRL_HI_CH    = 16;
    localparam int CMD_EQUAL     = 0;
    localparam int CMD_COPY_12   = 1;
    localparam int CMD_COPY_21   = 2;
    localparam int FRAC_MSB      = 31;
    localparam int CPL_MODE_BIT  = 31;
    localparam int CPL_OFS_W     = 24;
    localparam int CPL_SH_W      = 6;

    localparam logic signed [SMP_W-1:0] SMP_MAX = {1'b0, {(SMP_W-1){1'b1}}};
    localparam logic signed [SMP_W-1:0] SMP_MIN = {1'b1, {(SMP_W-1){1'b0}}};

    typedef enum logic [1:0] {FLD_TUNE_LO, FLD_TUNE_HI, FLD_AMP, FLD_PHASE} ddp_fld_t;

    typedef struct packed {
        logic [TUNE_W-1:0] frequency_tuning_word;
        logic [PAR_W-1:0]  amp;
        logic [PAR_W-1:0]  phase;
    } ddp_chan_t;
endpackage

// File: ddp_top.sv
// Dual-channel phase control with APB registers and the two DAC sample paths.
`timescale 1ns/1ps
module ddp_top (
    input  wire logic                             CLK_SYS_I,
    input  wire logic                             RSTN_I,
    input  wire logic                             PSEL_I,
    input  wire logic                             PENABLE_I,
    input  wire logic                             PWRITE_I,
    input  wire logic [ddp_pkg::ADDR_W-1:0]       PADDR_I,
    input  wire logic [31:0]                      PWDATA_I,
    output logic      [31:0]                      PRDATA_O,
    output logic                                  PREADY_O,
    output logic                                  PSLVERR_O,
    input  wire logic signed [ddp_pkg::SMP_W-1:0] SMP_ONE_I,
    input  wire logic signed [ddp_pkg::SMP_W-1:0] SMP_TWO_I,
    output logic      [ddp_pkg::PAR_W-1:0]        PHASE_ONE_O,
    output logic      [ddp_pkg::PAR_W-1:0]        PHASE_TWO_O,
    output logic      [ddp_pkg::PAR_W-1:0]        AMP_ONE_O,
    output logic      [ddp_pkg::PAR_W-1:0]        AMP_TWO_O,
    output logic signed [ddp_pkg::SMP_W-1:0]      DAC_ONE_O,
    output logic signed [ddp_pkg::SMP_W-1:0]      DAC_TWO_O
);
    import ddp_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [1:0] chan_hit(input logic [ADDR_W-1:0] a);
        chan_hit[0] = (a[ADDR_W-1:4] == OFS_CH_ONE[ADDR_W-1:4]);
        chan_hit[1] = (a[ADDR_W-1:4] == OFS_CH_TWO[ADDR_W-1:4]);
    endfunction

    function automatic ddp_fld_t fld_of(input logic [ADDR_W-1:0] a);
        fld_of = ddp_fld_t'(a[3:2]);
    endfunction

    // Ratio is a power of two so the reverse direction stays a cheap shift.
    function automatic logic [TUNE_W-1:0] couple_map(input logic [TUNE_W-1:0] v,
                                                     input logic [31:0]       cfg,
                                                     input logic              fwd);
        logic [TUNE_W-1:0]   ofs;
        logic [CPL_SH_W-1:0] sh;
        ofs = TUNE_W'(cfg[CPL_OFS_W-1:0]);
        sh  = cfg[CPL_SH_W-1:0];
        if (cfg[CPL_MODE_BIT]) begin
            couple_map = fwd ? v + ofs : v - ofs;
        end else begin
            couple_map = fwd ? v << sh : v >> sh;
        end
    endfunction

    function automatic logic signed [SMP_W-1:0] sat_add(input logic signed [SMP_W-1:0] a,
                                                        input logic signed [SMP_W-1:0] b);
        logic [SMP_W:0] s;
        s = {a[SMP_W-1], a} + {b[SMP_W-1], b};
        if (s[SMP_W] != s[SMP_W-1]) begin
            sat_add = s[SMP_W] ? SMP_MIN : SMP_MAX;
        end else begin
            sat_add = s[SMP_W-1:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_reg;
    logic rstn_reg;
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_s1_reg <= 1'b0;
            rstn_reg   <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rstn_reg   <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------
    ddp_chan_t        ch_reg [2];
    ddp_chan_t        ch_next [2];
    logic [31:0]      lo_reg [2];
    logic [31:0]      lo_next [2];
    logic [31:0]      cpl_reg [3];
    logic [31:0]      cpl_next [3];
    logic             lock_reg, lock_next, track_reg, track_next, couple_reg, couple_next;
    logic             sum1_reg, sum1_next, sum2_reg, sum2_next, hich_reg, hich_next;
    logic [MULT_W-1:0] mult_reg, mult_next;
    logic             pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic [31:0]      prdata_reg, prdata_next;
    logic [TUNE_W-1:0] acc_reg [2];
    logic [TUNE_W-1:0] acc_next [2];
    logic [TUNE_W-1:0] eff_tune [2];
    logic [TUNE_W-1:0] rnd_chk;
    logic             lock_eff, wr, acc_clr, eq_cmd, c, known;
    logic [1:0]       hit;
    ddp_fld_t         fld;
    ddp_chan_t        upd, oth;
    logic [31:0]      wd;

    assign lock_eff = lock_reg | track_reg;
    assign hit      = chan_hit(PADDR_I);
    assign fld      = fld_of(PADDR_I);
    assign c        = hit[1];
    assign wd       = PWDATA_I;
    assign wr       = PSEL_I & PENABLE_I & pready_reg & PWRITE_I & ~pslverr_reg;
    assign rnd_chk  = TUNE_W'({wd[TUNE_HI_W-1:0], lo_reg[0]}) + TUNE_W'(wd[FRAC_MSB]);

    always_comb begin
        ch_next      = ch_reg;
        lo_next      = lo_reg;
        cpl_next     = cpl_reg;
        lock_next    = lock_reg;
        track_next   = track_reg;
        couple_next  = couple_reg;
        sum1_next    = sum1_reg;
        sum2_next    = sum2_reg;
        hich_next    = hich_reg;
        mult_next    = mult_reg;
        prdata_next  = prdata_reg;
        pslverr_next = pslverr_reg;
        pready_next  = PSEL_I & PENABLE_I & ~pready_reg;
        acc_clr      = 1'b0;
        eq_cmd       = 1'b0;
        known        = (|hit) || PADDR_I == OFS_CTRL || PADDR_I == OFS_CMD
                       || PADDR_I == OFS_STATUS || PADDR_I == OFS_CPL_FREQ
                       || PADDR_I == OFS_CPL_AMP || PADDR_I == OFS_CPL_PH;
        upd          = ch_reg[c];
        case (fld)
            FLD_TUNE_HI: begin
                upd.frequency_tuning_word = TUNE_W'({wd[TUNE_HI_W-1:0], lo_reg[c]})
                                            + TUNE_W'(wd[FRAC_MSB]);
            end
            FLD_AMP:     upd.amp   = wd[PAR_W-1:0];
            FLD_PHASE:   upd.phase = wd[PAR_W-1:0];
            default:     upd = ch_reg[c];
        endcase
        oth = ch_reg[~c];
        case (fld)
            FLD_TUNE_HI: begin
                oth.frequency_tuning_word = couple_map(upd.frequency_tuning_word,
                                                       cpl_reg[0], ~c);
            end
            FLD_AMP:     oth.amp   = PAR_W'(couple_map(TUNE_W'(upd.amp), cpl_reg[1], ~c));
            FLD_PHASE:   oth.phase = PAR_W'(couple_map(TUNE_W'(upd.phase), cpl_reg[2], ~c));
            default:    oth = ch_reg[~c];
        endcase
        if (pready_next) begin
            pslverr_next = ~known | (hit[1] & track_reg & PWRITE_I);
            prdata_next  = '0;
            if (!PWRITE_I && (|hit)) begin
                case (fld)
                    FLD_TUNE_LO: prdata_next = lo_reg[c];
                    FLD_TUNE_HI: begin
                        prdata_next = 32'(ch_reg[c].frequency_tuning_word[TUNE_W-1:TUNE_LO_W]);
                    end
                    FLD_AMP:     prdata_next = 32'(ch_reg[c].amp);
                    default:    prdata_next = 32'(ch_reg[c].phase);
                endcase
            end else if (!PWRITE_I) begin
                case (PADDR_I)
                    OFS_CTRL: begin
                        prdata_next[CTRL_LOCK]              = lock_reg;
                        prdata_next[CTRL_TRACK]             = track_reg;
                        prdata_next[CTRL_COUPLE]            = couple_reg;
                        prdata_next[CTRL_SUM_ONE]           = sum1_reg;
                        prdata_next[CTRL_SUM_TWO]           = sum2_reg;
                        prdata_next[CTRL_MULT_LSB +: MULT_W] = mult_reg;
                        prdata_next[CTRL_HI_CH]             = hich_reg;
                    end
                    OFS_STATUS:   prdata_next = {acc_reg[1][TUNE_W-1 -: PAR_W],
                                                 acc_reg[0][TUNE_W-1 -: PAR_W]};
                    OFS_CPL_FREQ: prdata_next = cpl_reg[0];
                    OFS_CPL_AMP:  prdata_next = cpl_reg[1];
                    OFS_CPL_PH:   prdata_next = cpl_reg[2];
                    default:      prdata_next = '0;
                endcase
            end
        end
        if (wr) begin
            case (PADDR_I)
                OFS_CTRL: begin
                    track_next  = wd[CTRL_TRACK];
                    lock_next   = wd[CTRL_LOCK] | wd[CTRL_TRACK];
                    couple_next = wd[CTRL_COUPLE];
                    sum1_next   = wd[CTRL_SUM_ONE];
                    sum2_next   = wd[CTRL_SUM_TWO];
                    mult_next   = wd[CTRL_MULT_LSB +: MULT_W];
                    hich_next   = wd[CTRL_HI_CH];
                end
                OFS_CMD: begin
                    eq_cmd = wd[CMD_EQUAL];
                    if (wd[CMD_COPY_12]) begin
                        ch_next[1] = ch_reg[0];
                        lo_next[1] = lo_reg[0];
                    end else if (wd[CMD_COPY_21]) begin
                        ch_next[0] = ch_reg[1];
                        lo_next[0] = lo_reg[1];
                    end
                end
                OFS_CPL_FREQ: cpl_next[0] = wd;
                OFS_CPL_AMP:  cpl_next[1] = wd;
                OFS_CPL_PH:   cpl_next[2] = wd;
                default: begin
                    if (fld == FLD_TUNE_LO) begin
                        lo_next[c] = wd;
                        if (track_reg) begin
                            lo_next[~c] = wd;
                        end
                    end else if (|hit) begin
                        ch_next[c] = upd;
                        if (track_reg) begin
                            ch_next[~c] = upd;
                        end else if (couple_reg) begin
                            ch_next[~c] = oth;
                        end
                        acc_clr = lock_eff & (fld != FLD_AMP);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rstn_reg) begin
        if (!rstn_reg) begin
            ch_reg      <= '{default: '0};
            lo_reg      <= '{default: '0};
            cpl_reg     <= '{default: '0};
            {lock_reg, track_reg, couple_reg, sum1_reg, sum2_reg, hich_reg} <= '0;
            mult_reg    <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            ch_reg      <= ch_next;
            lo_reg      <= lo_next;
            cpl_reg     <= cpl_next;
            {lock_reg, track_reg, couple_reg, sum1_reg, sum2_reg, hich_reg} <=
                {lock_next, track_next, couple_next, sum1_next, sum2_next, hich_next};
            mult_reg    <= mult_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // ------------------------------------------------------------
    // Phase accumulators
    // ------------------------------------------------------------
    // The forced multiple trades frequency accuracy on the higher channel for zero drift.
    always_comb begin
        eff_tune[0] = ch_reg[0].frequency_tuning_word;
        eff_tune[1] = ch_reg[1].frequency_tuning_word;
        if (lock_reg && mult_reg != '0) begin
            eff_tune[hich_reg] = TUNE_W'(ch_reg[~hich_reg].frequency_tuning_word
                                         * mult_reg);
        end
        for (int i = 0; i < 2; i++) begin
            acc_next[i] = acc_reg[i] + eff_tune[i];
        end
        if (acc_clr) begin
            acc_next[0] = '0;
            acc_next[1] = '0;
        end else if (eq_cmd) begin
            acc_next[1] = acc_next[0];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge rstn_reg) begin
        if (!rstn_reg) begin
            acc_reg     <= '{default: '0};
            PHASE_ONE_O <= '0;
            PHASE_TWO_O <= '0;
            AMP_ONE_O   <= '0;
            AMP_TWO_O   <= '0;
            DAC_ONE_O   <= '0;
            DAC_TWO_O   <= '0;
        end else begin
            acc_reg     <= acc_next;
            PHASE_ONE_O <= acc_reg[0][TUNE_W-1 -: PAR_W] + ch_reg[0].phase;
            PHASE_TWO_O <= acc_reg[1][TUNE_W-1 -: PAR_W] + ch_reg[1].phase;
            AMP_ONE_O   <= ch_reg[0].amp;
            AMP_TWO_O   <= ch_reg[1].amp;
            DAC_ONE_O   <= sum1_reg ? sat_add(SMP_ONE_I, SMP_TWO_I) : SMP_ONE_I;
            DAC_TWO_O   <= sum2_reg ? sat_add(SMP_ONE_I, SMP_TWO_I) : SMP_TWO_I;
        end
    end
    assign PRDATA_O  = prdata_reg;
    assign PREADY_O  = pready_reg;
    assign PSLVERR_O = pslverr_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!rstn_reg);

    sequence s_ch_write(logic ch);
        wr && hit[ch];
    endsequence
    sequence s_track_setup_two;
        PSEL_I && PENABLE_I && !pready_reg && PWRITE_I && hit[1] && track_reg;
    endsequence

    a_accum_step: assert property ((!acc_clr && !eq_cmd) |=>
        acc_reg[1] == TUNE_W'($past(acc_reg[1]) + $past(eff_tune[1])))
        else $error("accumulator did not advance by its tuning word");
    a_tune_round_near: assert property ((s_ch_write(0) and fld == FLD_TUNE_HI) |=>
        ch_reg[0].frequency_tuning_word == $past(rnd_chk))
        else $error("tuning word not rounded to nearest");
    a_indep_other_still: assert property (
        (s_ch_write(0) and !track_reg && !couple_reg) |=> $stable(ch_reg[1]))
        else $error("independent write disturbed the other channel");
    a_lock_realign: assert property (
        (wr && lock_eff && (|hit) && fld == FLD_PHASE) |=>
        acc_reg[0] == '0 && acc_reg[1] == '0)
        else $error("locked timing write did not realign both channels");
    a_mult_enforce: assert property ((lock_reg && mult_reg != '0) |->
        eff_tune[hich_reg] == TUNE_W'(ch_reg[~hich_reg].frequency_tuning_word * mult_reg)
        && eff_tune[~hich_reg] == ch_reg[~hich_reg].frequency_tuning_word)
        else $error("higher channel word is not the integer multiple");
    a_equal_phase: assert property ((eq_cmd && !acc_clr) |=> acc_reg[0] == acc_reg[1])
        else $error("equal phase left accumulators different");
    a_out_select: assert property (!sum2_reg |=> DAC_TWO_O == $past(SMP_TWO_I))
        else $error("output two did not carry channel two");
    a_sum_saturate: assert property (
        (sum1_reg && SMP_ONE_I > 0 && SMP_TWO_I > 0) |=> DAC_ONE_O > 0)
        else $error("summed output wrapped");
    a_track_mirror: assert property (
        (s_ch_write(0) and track_reg && fld != FLD_TUNE_LO) |=> ch_reg[0] == ch_reg[1])
        else $error("track write not mirrored in the same cycle");
    a_track_reject: assert property (s_track_setup_two |=> PSLVERR_O ##1 $stable(ch_reg[1]))
        else $error("channel two write accepted in track mode");
    a_couple_offset: assert property (
        (s_ch_write(0) and couple_reg && !track_reg && fld == FLD_AMP
         && cpl_reg[1][CPL_MODE_BIT]) |=>
        ch_reg[1].amp == PAR_W'(ch_reg[0].amp + cpl_reg[1][PAR_W-1:0]))
        else $error("coupled amplitude not offset from channel one");
    a_copy_once: assert property (
        (wr && PADDR_I == OFS_CMD && wd[CMD_COPY_12]) |=> ch_reg[1] == ch_reg[0])
        else $error("copy did not transfer parameters");
endmodule

// File: ddp_dac_model.sv
// Partner model: channel sample sources and DAC capture for the phase control block.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Sample sources and DAC latch
// ---------------------------------------------------------------
module ddp_dac_model (
    input  wire logic                             clk_i,
    input  wire logic signed [ddp_pkg::SMP_W-1:0] wave_one_i,
    input  wire logic signed [ddp_pkg::SMP_W-1:0] wave_two_i,
    input  wire logic signed [ddp_pkg::SMP_W-1:0] dac_one_i,
    input  wire logic signed [ddp_pkg::SMP_W-1:0] dac_two_i,
    output logic signed      [ddp_pkg::SMP_W-1:0] smp_one_o,
    output logic signed      [ddp_pkg::SMP_W-1:0] smp_two_o,
    output logic signed      [ddp_pkg::SMP_W-1:0] code_one_o,
    output logic signed      [ddp_pkg::SMP_W-1:0] code_two_o
);
    import ddp_pkg::*;
    // Sources launch one sample per edge like a waveform engine; the DAC latches on the
    // same edge, so a code shows here one cycle after the design drives it.
    always @(posedge clk_i) begin
        smp_one_o  <= wave_one_i;
        smp_two_o  <= wave_two_i;
        code_one_o <= dac_one_i;
        code_two_o <= dac_two_i;
    end
endmodule

// File: ddp_tb_top.sv
// Self-checking testbench of the dual-channel phase control block.
`timescale 1ns/1ps
module ddp_tb_top;
    import ddp_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus, model and design
    // ---------------------------------------------------------------
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [ADDR_W-1:0]  paddr = '0;
    logic [31:0]        pwdata = '0;
    logic [31:0]        prdata, rd;
    logic               pready, pslverr, er;
    logic [SMP_W-1:0]   wave_one = '0, wave_two = '0, smp_one, smp_two, dac_one, dac_two;
    logic [SMP_W-1:0]   code_one, code_two, ph_one, ph_two, amp_one, amp_two;
    int                 err_total = 0, comparisons = 0, cyc = 0, stamp;
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ddp_top uut (.CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SMP_ONE_I(smp_one), .SMP_TWO_I(smp_two),
        .PHASE_ONE_O(ph_one), .PHASE_TWO_O(ph_two), .AMP_ONE_O(amp_one),
        .AMP_TWO_O(amp_two), .DAC_ONE_O(dac_one), .DAC_TWO_O(dac_two));
    ddp_dac_model u_dac (.clk_i(clk), .wave_one_i(wave_one),
        .wave_two_i(wave_two), .dac_one_i(dac_one), .dac_two_i(dac_two),
        .smp_one_o(smp_one), .smp_two_o(smp_two), .code_one_o(code_one),
        .code_two_o(code_two));
    // ---------------------------------------------------------------
    // Bus and check tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The master never assumes a latency: it waits for ready under a bound.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        chk(n < 64, 1'b1);
        rd = prdata;
        er = pslverr;
        stamp = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(rd, exp);
    endtask
    task automatic setftw(input logic [ADDR_W-1:0] base, input logic [31:0] hi);
        apb(1'b1, base, '0);
        apb(1'b1, base + 8'h04, hi);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_basic();
        logic [31:0] a0;
        int          c0;
        rdchk(OFS_CTRL, '0);
        rdchk(OFS_CMD, '0);
        rdchk(8'h3c, '0);
        chk(er, 1'b1);
        apb(1'b1, OFS_CH_ONE, 32'hffffffff);
        apb(1'b1, OFS_CH_ONE + 8'h04, 32'h80000005);
        rdchk(OFS_CH_ONE + 8'h04, 32'h6);
        apb(1'b1, OFS_CH_ONE + 8'h04, 32'h5);
        rdchk(OFS_CH_ONE + 8'h04, 32'h5);
        setftw(OFS_CH_ONE, 32'h10);
        apb(1'b0, OFS_STATUS, '0);
        a0 = rd;
        c0 = stamp;
        apb(1'b1, OFS_CH_TWO + 8'h08, 32'h55);
        apb(1'b0, OFS_STATUS, '0);
        chk(16'(rd[15:0] - a0[15:0]), 16'(stamp - c0));
        chk(rd[31:16], a0[31:16]);
    endtask
    task automatic t_lock();
        apb(1'b1, OFS_CTRL, 32'h1);
        setftw(OFS_CH_TWO, 32'h20);
        apb(1'b1, OFS_CH_ONE + 8'h0c, '0);
        apb(1'b0, OFS_STATUS, '0);
        chk(rd[31:16], 16'(rd[15:0] * 2));
        apb(1'b1, OFS_CTRL, 32'h00010301);
        setftw(OFS_CH_TWO, 32'h7);
        apb(1'b0, OFS_STATUS, '0);
        chk(rd[31:16], 16'(rd[15:0] * 3));
        apb(1'b1, OFS_CTRL, '0);
        setftw(OFS_CH_TWO, 32'h10);
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b0, OFS_STATUS, '0);
        chk(rd[31:16], rd[15:0]);
        apb(1'b1, OFS_CH_TWO + 8'h0c, 32'h40);
        repeat (2) @(posedge clk);
        chk(16'(ph_two - ph_one), 16'h0040);
    endtask
    task automatic t_track();
        apb(1'b1, OFS_CTRL, 32'h2);
        rdchk(OFS_CTRL, 32'h3);
        apb(1'b1, OFS_CH_TWO + 8'h08, 32'h0777);
        chk(er, 1'b1);
        apb(1'b1, OFS_CH_ONE + 8'h08, 32'h1234);
        repeat (4) begin
            @(posedge clk);
            chk(amp_one == 16'h1234, amp_two == 16'h1234);
        end
        chk(amp_two, 32'h1234);
    endtask
    task automatic t_couple();
        apb(1'b1, OFS_CTRL, 32'h4);
        apb(1'b1, OFS_CPL_AMP, 32'h80000010);
        apb(1'b1, OFS_CH_ONE + 8'h08, 32'h0100);
        repeat (3) @(posedge clk);
        chk(amp_two, 32'h0110);
        apb(1'b1, OFS_CH_TWO + 8'h08, 32'h0200);
        repeat (3) @(posedge clk);
        chk(amp_one, 32'h01f0);
        apb(1'b1, OFS_CPL_AMP, 32'h2);
        apb(1'b1, OFS_CH_ONE + 8'h08, 32'h0011);
        repeat (3) @(posedge clk);
        chk(amp_two, 32'h0044);
        apb(1'b1, OFS_CPL_FREQ, 32'h1);
        setftw(OFS_CH_ONE, 32'h8);
        rdchk(OFS_CH_TWO + 8'h04, 32'h10);
        apb(1'b1, OFS_CPL_PH, 32'h80000100);
        apb(1'b1, OFS_CH_ONE + 8'h0c, '0);
        rdchk(OFS_CH_TWO + 8'h0c, 32'h100);
    endtask
    task automatic t_copy();
        apb(1'b1, OFS_CTRL, '0);
        apb(1'b1, OFS_CH_ONE + 8'h08, 32'h0abc);
        apb(1'b1, OFS_CMD, 32'h2);
        apb(1'b1, OFS_CH_ONE + 8'h08, 32'h0001);
        repeat (3) @(posedge clk);
        chk(amp_two, 32'h0abc);
        apb(1'b1, OFS_CMD, 32'h4);
        repeat (3) @(posedge clk);
        chk(amp_one, 32'h0abc);
    endtask
    task automatic t_sum();
        logic [15:0] wa[4] = '{16'h7000, 16'h9000, 16'h0100, 16'h1234};
        logic [15:0] wb[4] = '{16'h2000, 16'h9000, 16'hff00, 16'h0042};
        logic [15:0] ws[4] = '{16'h7fff, 16'h8000, 16'h0000, 16'h1276};
        apb(1'b1, OFS_CTRL, 32'h18);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            wave_one <= wa[i];
            wave_two <= wb[i];
            repeat (5) @(posedge clk);
            chk(code_one, ws[i]);
            chk(code_two, ws[i]);
        end
        apb(1'b1, OFS_CTRL, 32'h08);
        repeat (3) @(posedge clk);
        chk(code_one, 32'h1276);
        chk(code_two, 32'h0042);
        apb(1'b1, OFS_CTRL, '0);
        repeat (3) @(posedge clk);
        chk(code_one, 32'h1234);
    endtask
    // ---------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ---------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_basic();
        t_lock();
        t_track();
        t_couple();
        t_copy();
        t_sum();
        give_verdict();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end
endmodule
